/* File: include/msb_pkg.sv */
package msb_pkg;

  // Two-wire device address, 7-bit form of the A0h/A1h byte
  localparam logic [6:0] MSB_DEV_ADDR       = 7'h50;

  // Clock rate and timing
  localparam int         MSB_CLK_MHZ        = 100;
  localparam int         MSB_RESET_PULSE_NS = 10_000;
  localparam int         MSB_RESET_PULSE_CYC =
    (MSB_RESET_PULSE_NS * MSB_CLK_MHZ + 999) / 1000;
  localparam int         MSB_RPW            = 10;
  localparam int         MSB_INIT_TIME_US   = 2_000_000;
  localparam int         MSB_INIT_CYC       = MSB_INIT_TIME_US * MSB_CLK_MHZ;
  localparam int         MSB_INIT_W         = 28;

  // Memory organisation
  localparam int         MSB_CHANNELS       = 4;
  localparam int         MSB_UPPER_PAGES    = 2;
  localparam int         MSB_UPPER_BYTES    = 256;
  localparam logic [7:0] MSB_STATUS_ADDR    = 8'h02;
  localparam logic [7:0] MSB_FLAG_ADDR      = 8'h03;
  localparam logic [7:0] MSB_MASK_ADDR      = 8'h56;
  localparam logic [7:0] MSB_PAGE_ADDR      = 8'h7F;
  localparam int         MSB_DNR_BIT        = 0;
  localparam int         MSB_INIT_FLAG_BIT  = 4;
  localparam logic [7:0] MSB_PAGE_RESET     = 8'h00;
  localparam logic [7:0] MSB_MASK_RESET     = 8'h00;
  localparam logic [7:0] MSB_MEM_RESET      = 8'h00;
  localparam logic [3:0] MSB_BYTE_BITS      = 4'h8;

  // Two-wire slave states
  typedef enum logic [2:0] {
    MSB_IDLE,
    MSB_ADDR,
    MSB_ADDR_ACK,
    MSB_WDATA,
    MSB_WACK,
    MSB_RDATA,
    MSB_RACK
  } msb_state_type;

endpackage

/* File: hw/msb_link.sv */
`timescale 1ns/1ps
`default_nettype none
module msb_link (
  input  wire logic       link_clk,
  input  wire logic       link_reset_n,
  input  wire logic       run,
  input  wire logic       select_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [7:0]      mem_addr,
  input  wire logic [7:0] mem_rdata,
  output logic [7:0]      mem_wdata,
  output logic            mem_wr,
  output logic            mem_rd
);
  import msb_pkg::*;

  logic [1:0]    scl_sync;   // Bus clock synchroniser
  logic [1:0]    sda_sync;   // Bus data synchroniser
  logic          scl_prev;   // Previous synced clock
  logic          sda_prev;   // Previous synced data
  msb_state_type state;      // Protocol state
  logic [7:0]    shreg;      // Shift register
  logic [3:0]    bitcnt;     // Bits moved in this byte
  logic          rw;         // Read transfer
  logic          first_byte; // Next written byte is the pointer
  logic [7:0]    pointer;    // Memory address pointer
  logic          scl_rise;
  logic          scl_fall;
  logic          start_cond;
  logic          stop_cond;
  logic          byte_end;

  // Pins cross into the link domain through two flops
  always_ff @(posedge link_clk)
  begin
    scl_sync <= {scl_sync[0], scl_in};
    sda_sync <= {sda_sync[0], sda_in};
  end

  // Edge history of the synced pins
  always_ff @(posedge link_clk)
  begin
    if (!link_reset_n)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else if (run)
    begin
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // Bus events; start and stop are data edges while the clock is high
  assign scl_rise   = scl_sync[1] & ~scl_prev;
  assign scl_fall   = ~scl_sync[1] & scl_prev;
  assign start_cond = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_cond  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
  assign byte_end   = scl_fall & (bitcnt == MSB_BYTE_BITS);

  // Memory strobes are combinational, address and data from flops
  assign mem_addr  = pointer;
  assign mem_wdata = shreg;
  assign mem_wr    = run & ~select_n & ~start_cond & ~stop_cond
                     & (state == MSB_WDATA) & byte_end & ~first_byte;
  assign mem_rd    = run & ~select_n & ~start_cond & ~stop_cond & scl_fall
                     & ((state == MSB_ADDR_ACK && rw) || state == MSB_RACK);
  assign sda_out   = 1'b0;

  // Byte engine: address match, acknowledge, write and read bytes
  always_ff @(posedge link_clk)
  begin
    if (!link_reset_n)
    begin
      state      <= MSB_IDLE;
      shreg      <= 8'h00;
      bitcnt     <= 4'h0;
      rw         <= 1'b0;
      first_byte <= 1'b0;
      pointer    <= 8'h00;
      sda_oe     <= 1'b0;
    end
    else if (run)
    begin
      if (select_n)
      begin
        // Deselected: drop any transfer, never drive the bus
        state  <= MSB_IDLE;
        sda_oe <= 1'b0;
      end
      else if (start_cond)
      begin
        // Start or repeated start while selected
        state  <= MSB_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (stop_cond)
      begin
        state  <= MSB_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        unique case (state)
          MSB_IDLE:
          begin
            sda_oe <= 1'b0;
          end
          MSB_ADDR, MSB_WDATA:
          begin
            if (scl_rise)
            begin
              shreg  <= {shreg[6:0], sda_sync[1]};
              bitcnt <= bitcnt + 4'h1;
            end
            else if (byte_end)
            begin
              bitcnt <= 4'h0;
              if (state == MSB_ADDR)
              begin
                if (shreg[7:1] == MSB_DEV_ADDR)
                begin
                  rw         <= shreg[0];
                  first_byte <= ~shreg[0];
                  sda_oe     <= 1'b1;
                  state      <= MSB_ADDR_ACK;
                end
                else
                begin
                  state <= MSB_IDLE;
                end
              end
              else
              begin
                // First written byte sets the pointer, others store
                pointer    <= first_byte ? shreg : pointer + 8'h01;
                first_byte <= 1'b0;
                sda_oe     <= 1'b1;
                state      <= MSB_WACK;
              end
            end
          end
          MSB_ADDR_ACK, MSB_RACK:
          begin
            if (state == MSB_RACK && scl_rise && sda_sync[1])
            begin
              // Host did not acknowledge: read ends
              state <= MSB_IDLE;
            end
            else if (scl_fall)
            begin
              if (state == MSB_RACK || rw)
              begin
                // Load next byte and drive its top bit
                shreg   <= {mem_rdata[6:0], 1'b0};
                sda_oe  <= ~mem_rdata[7];
                bitcnt  <= 4'h1;
                pointer <= pointer + 8'h01;
                state   <= MSB_RDATA;
              end
              else
              begin
                sda_oe <= 1'b0;
                state  <= MSB_WDATA;
              end
            end
          end
          MSB_WACK:
          begin
            if (scl_fall)
            begin
              sda_oe <= 1'b0;
              state  <= MSB_WDATA;
            end
          end
          MSB_RDATA:
          begin
            if (byte_end)
            begin
              sda_oe <= 1'b0;
              state  <= MSB_RACK;
            end
            else if (scl_fall)
            begin
              sda_oe <= ~shreg[7];
              shreg  <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: hw/msb_sideband.sv */
// What this block does
// - Answer bus commands while select is low
// - Ignore bus and drive nothing on it when deselected
// - Long reset pulse restores all settings to defaults
// - Completion interval starts on reset rising edge
// - Signal completion by attention with not-ready clear
// - Post completion at power-up without reset pulse
// - Low-power input high enters low-power mode
// - Attention low reports fault or critical status
// - Attention only pulls low or releases
// - Lower page 128 bytes plus paged upper area
// - Respond at device address A0h
// - Thresholds and identity live in upper pages
`timescale 1ns/1ps
`default_nettype none
module msb_sideband #(
  parameter int unsigned INIT_CYCLES = msb_pkg::MSB_INIT_CYC
) (
  input  wire logic                            mclk,
  input  wire logic                            reset_n,
  input  wire logic                            clk_en,
  input  wire logic                            link_clk,
  input  wire logic                            module_select_n,
  input  wire logic                            module_reset_n,
  input  wire logic                            low_power_request,
  input  wire logic                            scl_in,
  output logic                                 scl_out,
  output logic                                 scl_oe,
  input  wire logic                            sda_in,
  output logic                                 sda_out,
  output logic                                 sda_oe,
  output logic                                 attention_n_out,
  output logic                                 attention_n_oe,
  output logic                                 module_present_n,
  input  wire logic [msb_pkg::MSB_CHANNELS-1:0] fault_event,
  output logic                                 low_power_mode,
  output logic                                 settings_reset,
  output logic                                 data_not_ready
);
  import msb_pkg::*;

  // ---- Management clock domain ----
  logic [1:0]              mrst_sync;   // Reset pin synchroniser
  logic [1:0]              lpm_sync;    // Low-power pin synchroniser
  logic [1:0]              pend_sync;   // Pending flags from link side
  logic [MSB_RPW-1:0]      rst_cnt;     // Reset pin low time
  logic                    soft_reset;  // Full module reset active
  logic                    init_busy;   // Reset completion interval
  logic [MSB_INIT_W-1:0]   init_cnt;    // Completion interval counter
  logic [MSB_CHANNELS-1:0] fault_tog;   // Fault event toggles

  // ---- Link clock domain ----
  logic [1:0]              lrst_sync;   // Reset into link domain
  logic [1:0]              len_sync;    // Clock enable into link domain
  logic [1:0]              sel_sync;    // Select pin synchroniser
  logic [1:0]              srst_sync;   // Module reset level
  logic [1:0]              dnr_sync;    // Not-ready level
  logic                    dnr_prev;    // Not-ready history
  logic                    link_reset_n;
  logic                    link_run;
  logic [MSB_CHANNELS-1:0] fault_flag;  // Latched channel faults
  logic                    init_flag;   // Latched reset completion
  logic                    pending;     // Unread unmasked flags
  logic [7:0]              page_sel;    // Upper page select
  logic [7:0]              flag_mask;   // Channel flag masks
  logic [7:0]              clr_idx;     // Upper memory clear sweep
  logic [7:0]              upper_mem [0:MSB_UPPER_BYTES-1];
  logic [7:0]              mem_addr;
  logic [7:0]              mem_rdata;
  logic [7:0]              mem_wdata;
  logic                    mem_wr;
  logic                    mem_rd;
  logic                    flag_read;   // Flag byte read this cycle
  logic                    page_valid;  // Selected page exists
  logic [7:0]              upper_idx;   // Array index for upper access

  // Fixed pin levels: present is grounded, no bus clock stretching
  assign module_present_n = 1'b0;
  assign scl_out          = 1'b0;
  assign scl_oe           = 1'b0;
  assign attention_n_out  = 1'b0;

  // Pins into the management domain pass two flops
  always_ff @(posedge mclk)
  begin
    if (clk_en)
    begin
      mrst_sync <= {mrst_sync[0], module_reset_n};
      lpm_sync  <= {lpm_sync[0], low_power_request};
      pend_sync <= {pend_sync[0], pending};
    end
  end

  // Measure the reset pin low time; only a long pulse resets
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      rst_cnt    <= '0;
      soft_reset <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!mrst_sync[1])
      begin
        if (rst_cnt != MSB_RPW'(MSB_RESET_PULSE_CYC))
        begin
          rst_cnt <= rst_cnt + 1'b1;
        end
        else
        begin
          soft_reset <= 1'b1;
        end
      end
      else
      begin
        // Rising edge of the pin ends the reset itself
        rst_cnt    <= '0;
        soft_reset <= 1'b0;
      end
    end
  end

  // Completion interval; power-up starts it from reset too
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      init_busy <= 1'b1;
      init_cnt  <= '0;
    end
    else if (clk_en)
    begin
      if (soft_reset)
      begin
        // Held at zero until the pin is released
        init_busy <= 1'b1;
        init_cnt  <= '0;
      end
      else if (init_busy)
      begin
        if (init_cnt == MSB_INIT_W'(INIT_CYCLES - 1))
        begin
          init_busy <= 1'b0;
        end
        else
        begin
          init_cnt <= init_cnt + 1'b1;
        end
      end
    end
  end

  // Channel fault pulses become toggles for the crossing
  genvar gi;
  generate
    for (gi = 0; gi < MSB_CHANNELS; gi++)
    begin : g_fault_tog
      always_ff @(posedge mclk)
      begin
        if (!reset_n)
        begin
          fault_tog[gi] <= 1'b0;
        end
        else if (clk_en && fault_event[gi])
        begin
          fault_tog[gi] <= ~fault_tog[gi];
        end
      end
    end
  endgenerate

  // Registered pin outputs of the management domain
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      attention_n_oe <= 1'b0;
      low_power_mode <= 1'b0;
      settings_reset <= 1'b0;
      data_not_ready <= 1'b1;
    end
    else if (clk_en)
    begin
      attention_n_oe <= pend_sync[1];
      low_power_mode <= lpm_sync[1];
      settings_reset <= soft_reset;
      data_not_ready <= init_busy | soft_reset;
    end
  end

  // Level crossings into the link domain
  always_ff @(posedge link_clk)
  begin
    lrst_sync <= {lrst_sync[0], reset_n};
    len_sync  <= {len_sync[0], clk_en};
    sel_sync  <= {sel_sync[0], module_select_n};
    srst_sync <= {srst_sync[0], soft_reset};
    dnr_sync  <= {dnr_sync[0], init_busy};
  end

  assign link_reset_n = lrst_sync[1];
  assign link_run     = len_sync[1];

  // Two-wire slave engine
  msb_link u_link (
    .link_clk     (link_clk),
    .link_reset_n (link_reset_n),
    .run          (link_run),
    .select_n     (sel_sync[1]),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .sda_out      (sda_out),
    .sda_oe       (sda_oe),
    .mem_addr     (mem_addr),
    .mem_rdata    (mem_rdata),
    .mem_wdata    (mem_wdata),
    .mem_wr       (mem_wr),
    .mem_rd       (mem_rd)
  );

  assign flag_read = mem_rd & (mem_addr == MSB_FLAG_ADDR);

  // Per-channel fault flags: toggle crossing, clear on read
  generate
    for (gi = 0; gi < MSB_CHANNELS; gi++)
    begin : g_fault_flag
      logic [1:0] tog_sync; // Toggle synchroniser
      logic       tog_prev; // Toggle history
      always_ff @(posedge link_clk)
      begin
        if (!link_reset_n)
        begin
          tog_sync       <= 2'b00;
          tog_prev       <= 1'b0;
          fault_flag[gi] <= 1'b0;
        end
        else if (link_run)
        begin
          tog_sync <= {tog_sync[0], fault_tog[gi]};
          tog_prev <= tog_sync[1];
          if (srst_sync[1])
          begin
            fault_flag[gi] <= 1'b0;
          end
          else if (tog_sync[1] != tog_prev)
          begin
            // A new event beats a read in the same cycle
            fault_flag[gi] <= 1'b1;
          end
          else if (flag_read)
          begin
            fault_flag[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Completion flag follows the fall of not-ready
  always_ff @(posedge link_clk)
  begin
    if (!link_reset_n)
    begin
      dnr_prev  <= 1'b1;
      init_flag <= 1'b0;
      pending   <= 1'b0;
    end
    else if (link_run)
    begin
      dnr_prev <= dnr_sync[1];
      if (dnr_prev && !dnr_sync[1])
      begin
        // Not-ready already reads clear when this latches
        init_flag <= 1'b1;
      end
      else if (flag_read || srst_sync[1])
      begin
        init_flag <= 1'b0;
      end
      pending <= init_flag | (|(fault_flag & ~flag_mask[MSB_CHANNELS-1:0]));
    end
  end

  // User settings in the lower page, defaults on module reset
  always_ff @(posedge link_clk)
  begin
    if (!link_reset_n || srst_sync[1])
    begin
      page_sel  <= MSB_PAGE_RESET;
      flag_mask <= MSB_MASK_RESET;
    end
    else if (link_run && mem_wr)
    begin
      if (mem_addr == MSB_PAGE_ADDR)
      begin
        page_sel <= mem_wdata;
      end
      else if (mem_addr == MSB_MASK_ADDR)
      begin
        flag_mask <= mem_wdata;
      end
    end
  end

  assign page_valid = page_sel < 8'(MSB_UPPER_PAGES);
  assign upper_idx  = {page_sel[0], mem_addr[6:0]};

  // Upper pages: thresholds and identity, swept clear on module reset
  always_ff @(posedge link_clk)
  begin
    if (!link_reset_n)
    begin
      clr_idx <= 8'h00;
    end
    else if (link_run)
    begin
      if (srst_sync[1])
      begin
        upper_mem[clr_idx] <= MSB_MEM_RESET;
        clr_idx            <= clr_idx + 8'h01;
      end
      else
      begin
        clr_idx <= 8'h00;
        if (mem_wr && mem_addr[7] && page_valid)
        begin
          upper_mem[upper_idx] <= mem_wdata;
        end
      end
    end
  end

  // Read map: lower page fixed, upper area through page select
  always_comb
  begin
    mem_rdata = 8'h00;
    if (mem_addr[7])
    begin
      if (page_valid)
      begin
        mem_rdata = upper_mem[upper_idx];
      end
    end
    else
    begin
      unique case (mem_addr)
        MSB_STATUS_ADDR:
        begin
          mem_rdata[MSB_DNR_BIT] = dnr_sync[1];
        end
        MSB_FLAG_ADDR:
        begin
          mem_rdata[MSB_CHANNELS-1:0]  = fault_flag;
          mem_rdata[MSB_INIT_FLAG_BIT] = init_flag;
        end
        MSB_MASK_ADDR:
        begin
          mem_rdata = flag_mask;
        end
        MSB_PAGE_ADDR:
        begin
          mem_rdata = page_sel;
        end
        default:
        begin
          mem_rdata = 8'h00;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: bench/msb_sideband_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module msb_sideband_monitor #(
  parameter int unsigned INIT_CYCLES = 50
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_request,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic attention_n_out,
  input wire logic attention_n_oe,
  input wire logic module_present_n,
  input wire logic low_power_mode,
  input wire logic settings_reset,
  input wire logic data_not_ready
);
  import msb_pkg::*;
  logic [15:0] low_cnt;   // Cycles the reset pin has been low
  logic [31:0] init_cnt;  // Cycles spent in the completion interval
  // Measure the reset pin low time
  always_ff @(posedge mclk)
  begin
    if (module_reset_n)
      low_cnt <= 16'h0000;
    else if (low_cnt != 16'hFFFF)
      low_cnt <= low_cnt + 16'h0001;
  end
  // Measure the completion interval length
  always_ff @(posedge mclk)
  begin
    if (!reset_n || settings_reset)
      init_cnt <= 32'h0000_0000;
    else if (data_not_ready)
      init_cnt <= init_cnt + 32'h0000_0001;
  end
  property p_quiet;
    @(posedge link_clk) disable iff (!reset_n)
    module_select_n [*4] |-> !sda_oe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("data line driven while deselected");
  property p_lp_on;
    @(posedge mclk) disable iff (!reset_n)
    (reset_n && low_power_request) [*5] |-> low_power_mode;
  endproperty
  a_lp_on: assert property (p_lp_on)
    else $error("low power mode not entered");
  property p_lp_off;
    @(posedge mclk) disable iff (!reset_n)
    (reset_n && !low_power_request) [*5] |-> !low_power_mode;
  endproperty
  a_lp_off: assert property (p_lp_off)
    else $error("low power mode without request");
  property p_post;
    @(posedge mclk) disable iff (!reset_n)
    $fell(data_not_ready) |-> ##[1:40] attention_n_oe;
  endproperty
  a_post: assert property (p_post)
    else $error("completion not posted on attention");
  property p_hold;
    @(posedge mclk) disable iff (!reset_n)
    settings_reset |-> data_not_ready;
  endproperty
  a_hold: assert property (p_hold)
    else $error("ready flag clear during module reset");
  property p_init;
    @(posedge mclk) disable iff (!reset_n)
    $fell(data_not_ready) |->
      (init_cnt + 4 >= INIT_CYCLES) && (init_cnt <= INIT_CYCLES + 4);
  endproperty
  a_init: assert property (p_init)
    else $error("completion interval length wrong");
  property p_rst_min;
    @(posedge mclk) disable iff (!reset_n)
    $rose(settings_reset) |-> low_cnt >= MSB_RESET_PULSE_CYC;
  endproperty
  a_rst_min: assert property (p_rst_min)
    else $error("module reset on a short pulse");
  property p_rst_long;
    @(posedge mclk) disable iff (!reset_n)
    low_cnt == MSB_RESET_PULSE_CYC + 4 |-> settings_reset;
  endproperty
  a_rst_long: assert property (p_rst_long)
    else $error("long reset pulse not taken");
  property p_pins;
    @(posedge mclk) disable iff (!reset_n)
    !attention_n_out && !sda_out && !scl_oe && !module_present_n;
  endproperty
  a_pins: assert property (p_pins)
    else $error("pin driven high or clock stretched");
endmodule
bind msb_sideband msb_sideband_monitor #(.INIT_CYCLES(INIT_CYCLES)) u_mon (
  .mclk(mclk), .reset_n(reset_n), .link_clk(link_clk),
  .module_select_n(module_select_n), .module_reset_n(module_reset_n),
  .low_power_request(low_power_request), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe), .attention_n_out(attention_n_out),
  .attention_n_oe(attention_n_oe), .module_present_n(module_present_n),
  .low_power_mode(low_power_mode), .settings_reset(settings_reset),
  .data_not_ready(data_not_ready));
`default_nettype wire

/* File: bench/msb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module msb_host_model (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  localparam int HALF = 16;  // Bus phase in clock cycles, above 120 ns
  // Bus released at start
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Fixed bus phase
  task automatic pause();
    repeat (HALF) @(posedge mclk);
  endtask
  // Data moves only while the bus clock is low
  task automatic bit_io(input logic tx, output logic rx);
    pause();
    sda_low <= ~tx;
    pause();
    scl_low <= 1'b0;
    pause();
    rx = sda;
    scl_low <= 1'b1;
  endtask
  // Start or repeated start
  task automatic start();
    pause();
    sda_low <= 1'b0;
    pause();
    scl_low <= 1'b0;
    pause();
    sda_low <= 1'b1;
    pause();
    scl_low <= 1'b1;
  endtask
  // Stop, bus left released
  task automatic stop();
    pause();
    sda_low <= 1'b1;
    pause();
    scl_low <= 1'b0;
    pause();
    sda_low <= 1'b0;
    pause();
  endtask
  // Byte out MSB first, then sample the acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Byte in, then acknowledge or end with a refusal
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

/* File: bench/test_msb_sideband.sv */
`timescale 1ns/1ps
`default_nettype none
module test_msb_sideband;
  import msb_pkg::*;
  localparam int unsigned INIT = 50;  // Shortened completion interval
  logic       mclk, link_clk, reset_n, sel_n, rst_pin_n, lp_req;
  logic [3:0] fault;                   // Channel fault pulses
  logic       scl_out, scl_oe, sda_out, sda_oe, att_out, att_oe;
  logic       prs_n, lp_mode, set_rst, dnr, h_scl, h_sda;
  logic [7:0] d;                       // Read data
  logic       k;                       // Acknowledge seen
  int         bad_count, num_checks;
  wire        scl = ~(h_scl | scl_oe); // Pulled-up bus lines
  wire        sda = ~(h_sda | sda_oe);
  msb_sideband #(.INIT_CYCLES(INIT)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .link_clk(link_clk),
    .module_select_n(sel_n), .module_reset_n(rst_pin_n),
    .low_power_request(lp_req), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .attention_n_out(att_out), .attention_n_oe(att_oe),
    .module_present_n(prs_n), .fault_event(fault),
    .low_power_mode(lp_mode), .settings_reset(set_rst),
    .data_not_ready(dnr));
  msb_host_model u_h (.mclk(mclk), .sda(sda), .scl_low(h_scl),
    .sda_low(h_sda));
  // Clocks with unrelated phase
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait for attention
  task automatic wait_att();
    int i;
    for (i = 0; i < 400 && att_oe !== 1'b1; i++)
      @(posedge mclk);
    if (i == 400)
    begin
      chk(8'h00, 8'h01);
      tally_and_finish();
    end
  endtask
  // Pointer write then one data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_h.start();
    u_h.send({MSB_DEV_ADDR, 1'b0}, k);
    u_h.send(a, k);
    u_h.send(v, k);
    u_h.stop();
  endtask
  // Random read through a repeated start
  task automatic rd(input logic [6:0] dev, input logic [7:0] a);
    d = 8'h00;
    u_h.start();
    u_h.send({dev, 1'b0}, k);
    if (k)
    begin
      u_h.send(a, k);
      u_h.start();
      u_h.send({dev, 1'b1}, k);
      u_h.recv(1'b1, d);
    end
    u_h.stop();
  endtask
  // Main sequence
  initial
  begin
    {reset_n, sel_n, lp_req, fault} = '0;
    rst_pin_n = 1'b1;
    bad_count = 0;
    num_checks = 0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk({7'h00, dnr}, 8'h01);
    wait_att();
    chk({7'h00, dnr}, 8'h00);
    chk({4'h0, scl_out, sda_out, att_out, prs_n}, 8'h00);
    rd(MSB_DEV_ADDR, MSB_STATUS_ADDR);
    chk(d, 8'h00);
    rd(MSB_DEV_ADDR, MSB_FLAG_ADDR);
    chk(d, 8'h10);
    repeat (100) @(posedge mclk);
    chk({7'h00, att_oe}, 8'h00);
    sel_n <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(MSB_DEV_ADDR, MSB_FLAG_ADDR);
    chk({7'h00, k}, 8'h00);
    sel_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rd(7'h51, MSB_FLAG_ADDR);
    chk({7'h00, k}, 8'h00);
    wr(MSB_PAGE_ADDR, 8'h01);
    wr(8'h80, 8'h5A);
    wr(MSB_PAGE_ADDR, 8'h00);
    wr(8'h80, 8'hA5);
    rd(MSB_DEV_ADDR, 8'h80);
    chk(d, 8'hA5);
    wr(MSB_PAGE_ADDR, 8'h01);
    rd(MSB_DEV_ADDR, 8'h80);
    chk(d, 8'h5A);
    rd(MSB_DEV_ADDR, MSB_PAGE_ADDR);
    chk(d, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      fault <= 4'h1 << i;
      @(posedge mclk);
      fault <= 4'h0;
      wait_att();
      rd(MSB_DEV_ADDR, MSB_FLAG_ADDR);
      chk(d, 8'h01 << i);
      repeat (100) @(posedge mclk);
      chk({7'h00, att_oe}, 8'h00);
    end
    wr(MSB_MASK_ADDR, 8'h02);
    fault <= 4'h2;
    @(posedge mclk);
    fault <= 4'h0;
    repeat (200) @(posedge mclk);
    chk({7'h00, att_oe}, 8'h00);
    rd(MSB_DEV_ADDR, MSB_FLAG_ADDR);
    chk(d, 8'h02);
    lp_req <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({7'h00, lp_mode}, 8'h01);
    lp_req <= 1'b0;
    rst_pin_n <= 1'b0;
    repeat (500) @(posedge mclk);
    rst_pin_n <= 1'b1;
    repeat (10) @(posedge mclk);
    chk({6'h00, set_rst, dnr}, 8'h00);
    rst_pin_n <= 1'b0;
    repeat (1100) @(posedge mclk);
    chk({7'h00, set_rst}, 8'h01);
    rst_pin_n <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({7'h00, dnr}, 8'h01);
    wait_att();
    rd(MSB_DEV_ADDR, MSB_PAGE_ADDR);
    chk(d, MSB_PAGE_RESET);
    rd(MSB_DEV_ADDR, MSB_MASK_ADDR);
    chk(d, MSB_MASK_RESET);
    tally_and_finish();
  end
endmodule
`default_nettype wire
